/* File: fcap_access_port.sv */
// register-driven flash access port: restart, indirect address/data, log and image update
// ----------------------------------------------------------------------------
// Contract
// - writing 0x00 to restart control fully resets the device and re-sequences rails
// - restart is taken 50 us after the command so the acknowledge completes
// - writing 0xC0 shuts down rails and outputs, then monitoring resumes
// - indirect address held in low byte at 0x30, high at 0x31, both reset zero
// - pointer auto-increments so one 16-bit write at low byte loads whole address
// - data pair takes low byte first then high byte, loaded by auto-increment
// - reading data pair returns word at indirect address, low byte then high
// - a 48-byte read from address 0x1000 returns the flash error log
// - held in reset with log flag set, error register presents the log entries
// - hold-on-log mode stays in reset while log has entries, until cleared and a restart is written
// - alternative mode sequences rails after reset regardless of log entries
// - clearing the log at run time suspends monitoring while flash is busy
// - configuration image is 512 contiguous bytes at 0xE000 written indirectly
// - rail monitor sampling stops while configuration is written to flash
// - without a configuration, rail enables and digital outputs stay high-impedance
// - user data is 128 bytes at 0x1080 to 0x10FF, same write sequence
// - lock register resets locked 0x00, reads 0x01 while updating, 0x02 unlocked
// - log-present flag set at reset when log has entries, cleared only likewise
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "fcap_params.svh"

module fcap_access_port #(
  parameter int RESTART_DELAY_CYC = `FCAP_RESTART_DELAY_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        reg_start_i,
  input  wire logic [7:0]  reg_ptr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        hold_on_log_mode_i,
  input  wire logic [7:0]  run_error_i,
  input  wire logic        log_wr_i,
  input  wire logic [4:0]  log_idx_i,
  input  wire logic [15:0] log_data_i,
  input  wire logic        shutdown_done_i,
  input  wire logic [7:0]  rail_en_i,
  input  wire logic [3:0]  gpo_i,
  output logic             device_reset_o,
  output logic             sequence_enable_o,
  output logic             shutdown_req_o,
  output logic             monitor_hold_o,
  output logic [7:0]       rail_en_o,
  output logic [7:0]       rail_en_oe_o,
  output logic [3:0]       general_outputs_o,
  output logic [3:0]       general_outputs_oe_o
);
  import fcap_pkg::*;

  // --------------------------------------------------------------------------
  // indirect address decode
  // --------------------------------------------------------------------------
  function automatic fcap_region_e region_of(input logic [15:0] a);
    fcap_region_e r;
    r = RG_NONE;
    if (a >= `FCAP_LOG_BASE && a < `FCAP_USER_BASE)
    begin
      r = RG_LOG;
    end
    else if (a >= `FCAP_USER_BASE && a <= `FCAP_USER_LAST)
    begin
      r = RG_USER;
    end
    else if (a >= `FCAP_CFG_BASE && a <= `FCAP_CFG_LAST)
    begin
      r = RG_CFG;
    end
    return r;
  endfunction

  function automatic fcap_word_idx_t index_of(input logic [15:0] a);
    fcap_word_idx_t i;
    i = `FCAP_IDX_LOG + {3'b000, a[6:1]};
    if (region_of(a) == RG_USER)
    begin
      i = `FCAP_IDX_USER + {3'b000, a[6:1]};
    end
    else if (region_of(a) == RG_CFG)
    begin
      i = `FCAP_IDX_CFG + {1'b0, a[8:1]};
    end
    return i;
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  fcap_state_e    state_q;
  fcap_state_e    state_d;
  logic [7:0]     ptr_q;
  logic [7:0]     ptr_d;
  logic [15:0]    addr_q;
  logic [15:0]    addr_d;
  logic [7:0]     data_low_q;
  logic [7:0]     data_low_d;
  logic [7:0]     lock_q;
  logic [7:0]     lock_d;
  logic           nv_log_q;
  logic           nv_log_d;
  logic           log_armed_q;
  logic           log_armed_d;
  logic           erased_q;
  logic           erased_d;
  logic [5:0]     err_idx_q;
  logic [5:0]     err_idx_d;
  logic [13:0]    restart_cnt_q;
  logic [13:0]    restart_cnt_d;
  logic           reset_pulse_q;
  logic           reset_pulse_d;
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  logic           rvalid_q;
  logic           rvalid_d;
  logic [7:0]     rail_en_q;
  logic [3:0]     gpo_q;

  logic           flash_prog;
  logic           flash_erase;
  fcap_region_e   erase_region;
  fcap_word_idx_t rd_idx;
  logic [15:0]    rd_word;
  logic           flash_busy;
  logic           log_present;
  logic           cfg_valid;
  logic [15:0]    wr_word;
  logic           wr_allowed;
  logic           log_view;

  assign wr_word    = {reg_wdata_i, data_low_q};
  // locked or busy flash ignores data writes
  assign wr_allowed = (lock_q == `FCAP_LOCK_UNLOCKED) && !flash_busy;
  // log entries appear in the error register only while held with the flag set
  assign log_view   = (state_q == ST_HELD) && nv_log_q;
  assign rd_idx     = (ptr_q == `FCAP_OFS_ERROR) ? (`FCAP_IDX_LOG + {4'b0000, err_idx_q[5:1]})
                                                 : index_of(addr_q);

  // --------------------------------------------------------------------------
  // register access and sequencing next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    state_d       = state_q;
    ptr_d         = ptr_q;
    addr_d        = addr_q;
    data_low_d    = data_low_q;
    lock_d        = lock_q;
    nv_log_d      = nv_log_q;
    log_armed_d   = log_armed_q;
    erased_d      = erased_q;
    err_idx_d     = err_idx_q;
    restart_cnt_d = restart_cnt_q;
    reset_pulse_d = 1'b0;
    rdata_d       = rdata_q;
    rvalid_d      = 1'b0;
    flash_prog    = 1'b0;
    flash_erase   = 1'b0;
    erase_region  = RG_NONE;

    if (reg_start_i)
    begin
      ptr_d = reg_ptr_i;
    end
    else if (reg_wr_i)
    begin
      ptr_d = ptr_q + 8'd1;
      if (ptr_q == `FCAP_OFS_FLASH_LOCK)
      begin
        lock_d = reg_wdata_i;
        // a fresh lock or unlock starts a new update session
        erased_d    = 1'b0;
        log_armed_d = 1'b0;
      end
      else if (ptr_q == `FCAP_OFS_RESTART)
      begin
        if (reg_wdata_i == `FCAP_CMD_RESTART)
        begin
          state_d       = ST_RESTART_WAIT;
          restart_cnt_d = 14'(RESTART_DELAY_CYC - 1);
        end
        else if (reg_wdata_i == `FCAP_CMD_SHUTDOWN && state_q == ST_RUN)
        begin
          state_d = ST_SHUTDOWN;
        end
      end
      else if (ptr_q == `FCAP_OFS_ADDR_LOW)
      begin
        addr_d[7:0] = reg_wdata_i;
      end
      else if (ptr_q == `FCAP_OFS_ADDR_HIGH)
      begin
        addr_d[15:8] = reg_wdata_i;
      end
      else if (ptr_q == `FCAP_OFS_DATA_LOW)
      begin
        data_low_d = reg_wdata_i;
      end
      else if (ptr_q == `FCAP_OFS_DATA_HIGH)
      begin
        // the high byte completes the word; wrap back for the next word
        addr_d = addr_q + `FCAP_ADDR_STEP;
        ptr_d  = `FCAP_OFS_DATA_LOW;
        if (wr_allowed)
        begin
          if (wr_word == `FCAP_ERASE_KEY && addr_q == `FCAP_LOG_BASE)
          begin
            log_armed_d = 1'b1;
          end
          else if (wr_word == `FCAP_ERASE_KEY && addr_q == `FCAP_LOG_CLEAR_ADDR && log_armed_q)
          begin
            flash_erase  = 1'b1;
            erase_region = RG_LOG;
            log_armed_d  = 1'b0;
          end
          else if (wr_word == `FCAP_ERASE_KEY && !erased_q &&
                   (addr_q == `FCAP_CFG_BASE || addr_q == `FCAP_USER_BASE))
          begin
            // only the first key of a session erases; later words are data
            flash_erase  = 1'b1;
            erase_region = region_of(addr_q);
            erased_d     = 1'b1;
          end
          else if (region_of(addr_q) != RG_NONE)
          begin
            flash_prog = 1'b1;
          end
        end
      end
    end
    else if (reg_rd_i)
    begin
      rvalid_d = 1'b1;
      ptr_d    = ptr_q + 8'd1;
      rdata_d  = 8'h00;
      if (ptr_q == `FCAP_OFS_STATUS)
      begin
        rdata_d[`FCAP_STATUS_NVLOG_BIT] = nv_log_q;
      end
      else if (ptr_q == `FCAP_OFS_ERROR)
      begin
        ptr_d = ptr_q;
        if (log_view)
        begin
          rdata_d   = err_idx_q[0] ? rd_word[15:8] : rd_word[7:0];
          err_idx_d = (err_idx_q == `FCAP_LOG_LAST_BYTE) ? 6'd0 : err_idx_q + 6'd1;
        end
        else
        begin
          rdata_d = run_error_i;
        end
      end
      else if (ptr_q == `FCAP_OFS_FLASH_LOCK)
      begin
        rdata_d = flash_busy ? `FCAP_LOCK_BUSY : lock_q;
      end
      else if (ptr_q == `FCAP_OFS_ADDR_LOW)
      begin
        rdata_d = addr_q[7:0];
      end
      else if (ptr_q == `FCAP_OFS_ADDR_HIGH)
      begin
        rdata_d = addr_q[15:8];
      end
      else if (ptr_q == `FCAP_OFS_DATA_LOW)
      begin
        rdata_d = (region_of(addr_q) != RG_NONE) ? rd_word[7:0] : 8'h00;
      end
      else if (ptr_q == `FCAP_OFS_DATA_HIGH)
      begin
        rdata_d = (region_of(addr_q) != RG_NONE) ? rd_word[15:8] : 8'h00;
        // streaming the data pair walks memory, so 48 bytes from 0x1000 is the log
        addr_d  = addr_q + `FCAP_ADDR_STEP;
        ptr_d   = `FCAP_OFS_DATA_LOW;
      end
    end

    case (state_q)
      ST_INIT:
      begin
        nv_log_d = log_present;
        if (hold_on_log_mode_i && log_present)
        begin
          state_d = ST_HELD;
        end
        else
        begin
          state_d = ST_RUN;
        end
      end
      ST_HELD:
      begin
      end
      ST_RUN:
      begin
      end
      ST_RESTART_WAIT:
      begin
        if (restart_cnt_q == 14'd0)
        begin
          // full reset of the access state, then the startup decision again
          state_d       = ST_INIT;
          reset_pulse_d = 1'b1;
          ptr_d         = `FCAP_RST_BYTE;
          addr_d        = `FCAP_RST_ADDR;
          data_low_d    = `FCAP_RST_BYTE;
          lock_d        = `FCAP_LOCK_LOCKED;
          log_armed_d   = 1'b0;
          erased_d      = 1'b0;
          err_idx_d     = 6'd0;
        end
        else
        begin
          restart_cnt_d = restart_cnt_q - 14'd1;
        end
      end
      ST_SHUTDOWN:
      begin
        if (shutdown_done_i)
        begin
          state_d = ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_INIT;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q       <= ST_INIT;
      ptr_q         <= `FCAP_RST_BYTE;
      addr_q        <= `FCAP_RST_ADDR;
      data_low_q    <= `FCAP_RST_BYTE;
      lock_q        <= `FCAP_LOCK_LOCKED;
      nv_log_q      <= 1'b0;
      log_armed_q   <= 1'b0;
      erased_q      <= 1'b0;
      err_idx_q     <= 6'd0;
      restart_cnt_q <= 14'd0;
      reset_pulse_q <= 1'b0;
      rdata_q       <= `FCAP_RST_BYTE;
      rvalid_q      <= 1'b0;
      rail_en_q     <= 8'h00;
      gpo_q         <= 4'h0;
    end
    else
    begin
      state_q       <= state_d;
      ptr_q         <= ptr_d;
      addr_q        <= addr_d;
      data_low_q    <= data_low_d;
      lock_q        <= lock_d;
      nv_log_q      <= nv_log_d;
      log_armed_q   <= log_armed_d;
      erased_q      <= erased_d;
      err_idx_q     <= err_idx_d;
      restart_cnt_q <= restart_cnt_d;
      reset_pulse_q <= reset_pulse_d;
      rdata_q       <= rdata_d;
      rvalid_q      <= rvalid_d;
      rail_en_q     <= rail_en_i;
      gpo_q         <= gpo_i;
    end
  end

  // --------------------------------------------------------------------------
  // flash array
  // --------------------------------------------------------------------------
  fcap_flash_array u_flash (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .prog_i         (flash_prog),
    .prog_idx_i     (index_of(addr_q)),
    .prog_data_i    (wr_word),
    .erase_i        (flash_erase),
    .erase_region_i (erase_region),
    .log_wr_i       (log_wr_i),
    .log_idx_i      (log_idx_i),
    .log_data_i     (log_data_i),
    .rd_idx_i       (rd_idx),
    .rd_data_o      (rd_word),
    .busy_o         (flash_busy),
    .log_present_o  (log_present),
    .config_valid_o (cfg_valid)
  );

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rdata_o          = rdata_q;
  assign reg_rvalid_o         = rvalid_q;
  assign device_reset_o       = reset_pulse_q;
  assign sequence_enable_o    = (state_q == ST_RUN) || (state_q == ST_SHUTDOWN);
  assign shutdown_req_o       = (state_q == ST_SHUTDOWN);
  // monitoring pauses for any flash program or erase
  assign monitor_hold_o       = flash_busy;
  assign rail_en_o            = rail_en_q;
  assign general_outputs_o    = gpo_q;
  // an unconfigured part must not drive enables into the supplies
  assign rail_en_oe_o         = {8{cfg_valid}};
  assign general_outputs_oe_o = {4{cfg_valid}};

endmodule
`default_nettype wire

/* File: fcap_params.svh */
// register offsets, command values, flash map and timing constants of the flash access port
`ifndef FCAP_PARAMS_SVH
`define FCAP_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define FCAP_OFS_STATUS       8'h27
`define FCAP_OFS_ERROR        8'h28
`define FCAP_OFS_FLASH_LOCK   8'h2e
`define FCAP_OFS_RESTART      8'h2f
`define FCAP_OFS_ADDR_LOW     8'h30
`define FCAP_OFS_ADDR_HIGH    8'h31
`define FCAP_OFS_DATA_LOW     8'h32
`define FCAP_OFS_DATA_HIGH    8'h33

// ----------------------------------------------------------------------------
// field layout, values and reset values
// ----------------------------------------------------------------------------
`define FCAP_RST_BYTE         8'h00
`define FCAP_RST_ADDR         16'h0000
`define FCAP_STATUS_NVLOG_BIT 5
`define FCAP_CMD_RESTART      8'h00
`define FCAP_CMD_SHUTDOWN     8'hc0
`define FCAP_LOCK_LOCKED      8'h00
`define FCAP_LOCK_BUSY        8'h01
`define FCAP_LOCK_UNLOCKED    8'h02
`define FCAP_ERASE_KEY        16'hbadc
`define FCAP_ERASED_WORD      16'hffff
`define FCAP_ADDR_STEP        16'h0002

// ----------------------------------------------------------------------------
// flash map
// ----------------------------------------------------------------------------
`define FCAP_LOG_BASE         16'h1000
`define FCAP_LOG_CLEAR_ADDR   16'h107e
`define FCAP_USER_BASE        16'h1080
`define FCAP_USER_LAST        16'h10ff
`define FCAP_CFG_BASE         16'he000
`define FCAP_CFG_LAST         16'he1ff
`define FCAP_LOG_LAST_BYTE    6'd47
`define FCAP_WORDS            384
`define FCAP_IDX_LOG          9'd0
`define FCAP_IDX_USER         9'd64
`define FCAP_IDX_CFG          9'd128
`define FCAP_IDX_CFG_LAST     9'd383

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FCAP_CLK_PERIOD_NS     5
`define FCAP_RESTART_DELAY_NS  50000
`define FCAP_RESTART_DELAY_CYC (`FCAP_RESTART_DELAY_NS / `FCAP_CLK_PERIOD_NS)
`define FCAP_FLASH_OP_CYC      8'd64

`endif

/* File: fcap_pkg.sv */
// types shared by the flash access port and its flash array
package fcap_pkg;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_HELD,
    ST_RUN,
    ST_RESTART_WAIT,
    ST_SHUTDOWN
  } fcap_state_e;

  typedef enum logic [1:0] {
    RG_NONE,
    RG_LOG,
    RG_USER,
    RG_CFG
  } fcap_region_e;

  typedef logic [8:0] fcap_word_idx_t;

endpackage

/* File: fcap_flash_array.sv */
// internal flash word store with region erase, programming and busy timing
`timescale 1ns/10ps
`default_nettype none
`include "fcap_params.svh"

module fcap_flash_array (
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  input  wire logic                    prog_i,
  input  wire fcap_pkg::fcap_word_idx_t prog_idx_i,
  input  wire logic [15:0]             prog_data_i,
  input  wire logic                    erase_i,
  input  wire fcap_pkg::fcap_region_e  erase_region_i,
  input  wire logic                    log_wr_i,
  input  wire logic [4:0]              log_idx_i,
  input  wire logic [15:0]             log_data_i,
  input  wire fcap_pkg::fcap_word_idx_t rd_idx_i,
  output logic [15:0]                  rd_data_o,
  output logic                         busy_o,
  output logic                         log_present_o,
  output logic                         config_valid_o
);
  import fcap_pkg::*;

  // --------------------------------------------------------------------------
  // operation acceptance and busy timer
  // --------------------------------------------------------------------------
  logic [7:0]     busy_cnt_q;
  logic [7:0]     busy_cnt_d;
  logic           host_go;
  logic           log_go;
  logic           log_present_q;
  logic           log_present_d;
  logic           cfg_valid_q;
  logic           cfg_valid_d;
  fcap_word_idx_t log_word_idx;

  assign busy_o        = (busy_cnt_q != 8'h00);
  // host operations win over the logger; a logger write during busy is dropped
  assign host_go       = (prog_i | erase_i) & ~busy_o;
  assign log_go        = log_wr_i & ~busy_o & ~prog_i & ~erase_i;
  assign log_word_idx  = `FCAP_IDX_LOG + {4'b0000, log_idx_i};
  assign log_present_o = log_present_q;
  assign config_valid_o = cfg_valid_q;

  always_comb
  begin
    busy_cnt_d    = busy_cnt_q;
    log_present_d = log_present_q;
    cfg_valid_d   = cfg_valid_q;
    if (host_go | log_go)
    begin
      busy_cnt_d = `FCAP_FLASH_OP_CYC;
    end
    else if (busy_o)
    begin
      busy_cnt_d = busy_cnt_q - 8'd1;
    end
    if (host_go && erase_i && erase_region_i == RG_LOG)
    begin
      log_present_d = 1'b0;
    end
    if (log_go || (host_go && prog_i && prog_idx_i < `FCAP_IDX_USER))
    begin
      log_present_d = 1'b1;
    end
    if (host_go && erase_i && erase_region_i == RG_CFG)
    begin
      cfg_valid_d = 1'b0;
    end
    // the image counts as loaded once its final word lands
    if (host_go && prog_i && prog_idx_i == `FCAP_IDX_CFG_LAST)
    begin
      cfg_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      busy_cnt_q    <= 8'h00;
      log_present_q <= 1'b0;
      cfg_valid_q   <= 1'b0;
    end
    else
    begin
      busy_cnt_q    <= busy_cnt_d;
      log_present_q <= log_present_d;
      cfg_valid_q   <= cfg_valid_d;
    end
  end

  // --------------------------------------------------------------------------
  // word store; contents are not touched by reset, as flash would not be
  // --------------------------------------------------------------------------
  logic [15:0] mem_q [`FCAP_WORDS];
  logic [15:0] mem_d [`FCAP_WORDS];

  for (genvar g = 0; g < `FCAP_WORDS; g++)
  begin : g_word
    localparam fcap_region_e WORD_REGION = (g < 64) ? RG_LOG : (g < 128) ? RG_USER : RG_CFG;
    always_comb
    begin
      mem_d[g] = mem_q[g];
      if (host_go && erase_i && erase_region_i == WORD_REGION)
      begin
        mem_d[g] = `FCAP_ERASED_WORD;
      end
      else if (host_go && prog_i && prog_idx_i == 9'(g))
      begin
        mem_d[g] = prog_data_i;
      end
      else if (log_go && log_word_idx == 9'(g))
      begin
        mem_d[g] = log_data_i;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    mem_q <= mem_d;
  end

  assign rd_data_o = mem_q[rd_idx_i];

endmodule
`default_nettype wire

/* File: fcap_chk_sva.sv */
// assertions on the pins of the flash access port
`timescale 1ns/10ps
`default_nettype none
module fcap_chk #(
  parameter int RESTART_DELAY_CYC = 20
) (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       reg_start_i,
  input wire logic [7:0] reg_ptr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic       log_wr_i,
  input wire logic       reg_rvalid_o,
  input wire logic       device_reset_o,
  input wire logic       sequence_enable_o,
  input wire logic       shutdown_req_o,
  input wire logic       monitor_hold_o,
  input wire logic [7:0] rail_en_oe_o,
  input wire logic [3:0] general_outputs_oe_o
);
  localparam int RD = RESTART_DELAY_CYC + 1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----
  // properties
  // ----
  sequence s_cmd(logic [7:0] v);
    reg_start_i && reg_ptr_i == 8'h2f ##1 reg_wr_i && reg_wdata_i == v;
  endsequence
  property p_rv; reg_rd_i && !reg_start_i && !reg_wr_i |=> reg_rvalid_o; endproperty
  property p_off; s_cmd(8'h00) |=> !sequence_enable_o; endproperty
  property p_gap; s_cmd(8'h00) |=> !device_reset_o [*8]; endproperty
  property p_dly; s_cmd(8'h00) |-> ##RD device_reset_o; endproperty
  property p_shut; s_cmd(8'hc0) ##0 (sequence_enable_o && !shutdown_req_o) |=> shutdown_req_o;
  endproperty
  property p_hold; $rose(monitor_hold_o) && $past(reg_wr_i) |-> ##63 monitor_hold_o ##1
    !monitor_hold_o; endproperty
  property p_src; $rose(monitor_hold_o) |-> $past(reg_wr_i || log_wr_i); endproperty
  property p_oe; {rail_en_oe_o, general_outputs_oe_o} inside {12'h000, 12'hfff}; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  a_off: assert property (p_off) else $error("rails kept after restart");
  a_gap: assert property (p_gap) else $error("restart too early");
  a_dly: assert property (p_dly) else $error("restart not on time");
  a_shut: assert property (p_shut) else $error("shutdown not started");
  a_hold: assert property (p_hold) else $error("monitor hold length");
  a_src: assert property (p_src) else $error("flash op without write");
  a_oe: assert property (p_oe) else $error("output enables split");
endmodule
`default_nettype wire

/* File: fcap_host_model.sv */
// host model speaking the register port of the flash access port
`timescale 1ns/10ps
`default_nettype none
module fcap_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic            reg_start_o,
  output logic [7:0]      reg_ptr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o
);
  logic [7:0] wb [2];
  logic [7:0] rb [48];
  initial
    {reg_start_o, reg_wr_o, reg_rd_o, reg_ptr_o, reg_wdata_o} = 19'h0;
  // ----
  // transfers
  // ----
  // low byte first; released lines carry inverted values, never the old ones
  task automatic xfer(input logic [7:0] p, input int n, input logic w);
    @(posedge clock_i);
    reg_start_o <= 1'b1;
    reg_ptr_o <= p;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge clock_i);
      reg_start_o <= 1'b0;
      reg_ptr_o <= ~p;
      reg_wr_o <= w && i < n;
      reg_rd_o <= !w && i < n;
      reg_wdata_o <= (w && i < n) ? wb[i%2] : ~reg_wdata_o;
      #1;
      if (!w && i > 0)
        rb[i-1] = reg_rvalid_i ? reg_rdata_i : 8'hxx;
    end
  endtask
  task automatic w(input logic [7:0] p, input logic [15:0] d, input int n);
    {wb[1], wb[0]} = d;
    xfer(p, n, 1'b1);
  endtask
  // writes are refused while the flash is busy, so wait for the lock to leave 0x01
  task automatic idle();
    rb[0] = 8'h01;
    repeat (40)
      if (rb[0] === 8'h01)
        xfer(8'h2e, 1, 1'b0);
  endtask
endmodule
`default_nettype wire

/* File: fcap_access_port_test.sv */
// self-checking bench for the flash access port
`timescale 1ns/10ps
`default_nettype none
module fcap_access_port_test;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hold = 1'b0;
  logic        sd_done = 1'b0;
  logic        log_wr = 1'b0;
  logic [4:0]  log_idx = 5'h00;
  logic [15:0] log_data = 16'h0000;
  logic        start, wr, rd, rvalid, seq_en, sd_req;
  logic [7:0]  ptr, wdata, rdata, oe, rout;
  logic [3:0]  goe, gout;
  logic [15:0] uexp [3] = '{16'hbeef, 16'hcafe, 16'hffff};
  int          error_cnt = 0;
  int          n_checks = 0;
  always #2.5 clock_i = ~clock_i;
  fcap_host_model h (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_start_o(start), .reg_ptr_o(ptr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
  fcap_access_port #(.RESTART_DELAY_CYC(20)) uut (.clock_i(clock_i), .rst_i(rst_i),
    .reg_start_i(start), .reg_ptr_i(ptr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .hold_on_log_mode_i(hold),
    .run_error_i(8'ha5), .log_wr_i(log_wr), .log_idx_i(log_idx), .log_data_i(log_data),
    .shutdown_done_i(sd_done), .rail_en_i(8'h3c), .gpo_i(4'h9), .device_reset_o(),
    .sequence_enable_o(seq_en), .shutdown_req_o(sd_req), .monitor_hold_o(), .rail_en_o(rout),
    .rail_en_oe_o(oe), .general_outputs_o(gout), .general_outputs_oe_o(goe));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] wd(input int i);
    return {h.rb[2*i+1], h.rb[2*i]};
  endfunction
  task automatic fw(input logic [15:0] a, input logic [15:0] d);
    h.w(8'h30, a, 2);
    h.w(8'h32, d, 2);
    h.idle();
  endtask
  task automatic cmd(input logic [7:0] v);
    h.w(8'h2f, {8'h00, v}, 1);
    repeat (30) @(posedge clock_i);
    #1;
  endtask
  task automatic logchk(input string nm);
    for (int i = 0; i < 24; i++)
      chk(nm, 16'h0a00 + 16'(i), wd(i));
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk("seq_en", 16'h0001, seq_en);
    chk("oe", 16'h0000, {goe, oe});
    h.xfer(8'h2e, 4, 1'b0);
    chk("addr", 16'h0000, {h.rb[3], h.rb[2]});
    chk("lock", 16'h0000, h.rb[0]);
    h.w(8'h30, 16'h1234, 2);
    h.xfer(8'h30, 2, 1'b0);
    chk("addr", 16'h1234, wd(0));
    h.w(8'h2e, 16'h0002, 1);
    h.xfer(8'h2e, 1, 1'b0);
    chk("lock", 16'h0002, h.rb[0]);
    fw(16'h1080, 16'hbadc);
    fw(16'h1080, 16'hbeef);
    fw(16'h1082, 16'hcafe);
    h.w(8'h2e, 16'h0000, 1);
    fw(16'h1080, 16'h0000);
    h.w(8'h30, 16'h1080, 2);
    h.xfer(8'h32, 6, 1'b0);
    for (int i = 0; i < 3; i++)
      chk("user", uexp[i], wd(i));
    @(posedge clock_i);
    log_wr <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      log_idx <= 5'(i);
      log_data <= 16'h0a00 + 16'(i);
      repeat (65) @(posedge clock_i); // logger is refused while flash is busy
    end
    log_wr <= 1'b0;
    cmd(8'h00);
    chk("seq_en", 16'h0001, seq_en);
    @(posedge clock_i);
    hold <= 1'b1;
    h.w(8'h30, 16'h1000, 2);
    h.xfer(8'h32, 48, 1'b0);
    logchk("run log");
    cmd(8'h00);
    chk("held", 16'h0000, seq_en);
    repeat (2)
    begin
      h.xfer(8'h27, 1, 1'b0);
      chk("nvlog", 16'h0001, h.rb[0][5]);
    end
    h.xfer(8'h28, 48, 1'b0);
    logchk("err view");
    h.w(8'h2e, 16'h0002, 1);
    fw(16'h1000, 16'hbadc);
    fw(16'h107e, 16'hbadc);
    h.w(8'h2e, 16'h0000, 1);
    cmd(8'h00);
    chk("seq_en", 16'h0001, seq_en);
    h.xfer(8'h27, 2, 1'b0);
    chk("nvlog", 16'h0000, h.rb[0][5]);
    chk("run err", 16'h00a5, h.rb[1]);
    h.w(8'h2f, 16'h00c0, 1);
    chk("sd_req", 16'h0001, sd_req);
    @(posedge clock_i);
    sd_done <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("sd_req", 16'h0000, sd_req);
    h.w(8'h2e, 16'h0002, 1);
    fw(16'he000, 16'hbadc);
    for (int i = 0; i < 256; i++)
      fw(16'he000 + 16'(2 * i), 16'(i));
    h.w(8'h2e, 16'h0000, 1);
    h.w(8'h30, 16'he1fe, 2);
    h.xfer(8'h32, 2, 1'b0);
    chk("cfg", 16'h00ff, wd(0));
    chk("oe", 16'h0fff, {goe, oe});
    chk("outs", 16'h093c, {gout, rout});
    print_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge clock_i);
    error_cnt++;
    print_verdict();
  end
endmodule
bind fcap_access_port fcap_chk #(.RESTART_DELAY_CYC(RESTART_DELAY_CYC)) chk (.*);
`default_nettype wire
